// File: fifo_match_pkg.sv
// shared constants, types and carriers for the bus-matching fifo read block
package fifo_match_pkg;

	// ****************************************
	// storage geometry
	// ****************************************
	localparam int DEPTH = 256;
	localparam int ADDR_W = 8;
	localparam int PTR_W = 9;
	localparam int WORD_W = 36;
	localparam logic [8:0] DEPTH_COUNT = 9'h100;

	// ****************************************
	// register map (byte addresses) and reset values
	// ****************************************
	localparam logic [3:0] OFS_AE_OFFSET = 4'h0;
	localparam logic [3:0] OFS_AF_OFFSET = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_LEVEL = 4'hc;
	localparam logic [7:0] AE_OFFSET_RESET = 8'h08;
	localparam logic [7:0] AF_OFFSET_RESET = 8'h08;

	// ****************************************
	// port b lane layout
	// ****************************************
	localparam logic [35:0] MASK_LONG = 36'hf_ffff_ffff;
	localparam logic [35:0] MASK_WORD = 36'h0_0003_ffff;
	localparam logic [35:0] MASK_BYTE = 36'h0_0000_01ff;
	localparam logic [1:0] LAST_LONG = 2'h0;
	localparam logic [1:0] LAST_WORD = 2'h1;
	localparam logic [1:0] LAST_BYTE = 2'h3;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		SIZE_LONG = 2'b00,
		SIZE_WORD = 2'b01,
		SIZE_BYTE = 2'b11
	} size_mode_t;

	typedef struct packed {
		logic chip_select_n;
		logic write_read;
		logic enable;
		logic mailbox_select;
		logic [35:0] data;
	} port_a_req_t;

	typedef struct packed {
		logic chip_select_n;
		logic write_read;
		logic enable;
		logic mailbox_select;
	} port_b_req_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic empty_n;
		logic full_n;
		logic almost_empty_n;
		logic almost_full_n;
		logic mailbox_one_n;
	} flags_t;

	typedef struct packed {
		logic [1:0] piece_index;
		logic fall_through;
		logic endian_big;
		size_mode_t size_mode;
		flags_t flags;
	} status_t;

endpackage

// File: fifo_bus_match.sv
// bus-matching fifo: port a long-word writes, port b 36/18/9-bit reads, flags and a-to-b mailbox
`timescale 1ns/1ps
// ****************************************
// ****************************************
module fifo_bus_match
	import fifo_match_pkg::*;
(
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic BUS_MATCH_SELECT,
	input wire logic SIZE_SELECT,
	input wire logic ENDIAN_ORDER_SELECT,
	input wire logic FALL_THROUGH_MODE,
	input wire port_a_req_t PORT_A,
	input wire port_b_req_t PORT_B,
	input wire reg_req_t REG_REQ,
	output logic [31:0] REG_RDATA,
	output logic [35:0] DATA_B,
	output flags_t FLAGS
);

	// ****************************************
	// helpers
	// ****************************************

	// pick one piece of a long word and place it in the low lanes
	function automatic logic [35:0] piece_of(input logic [35:0] w, input size_mode_t m, input logic big,
		input logic [1:0] idx);
		logic [1:0] lane;
		logic [35:0] r;
		lane = 2'h0;
		r = 36'h0;
		unique case (m)
			SIZE_LONG: begin
				r = w;
			end
			SIZE_WORD: begin
				r = (big ^ idx[0]) ? {18'h0, w[35:18]} : {18'h0, w[17:0]};
			end
			SIZE_BYTE: begin
				lane = big ? (2'h3 - idx) : idx;
				r = {27'h0, w[lane * 9 +: 9]};
			end
			default: begin
				r = w;
			end
		endcase
		return r;
	endfunction

	// index of the final piece of a long word
	function automatic logic [1:0] last_of(input size_mode_t m);
		logic [1:0] r;
		r = LAST_LONG;
		unique case (m)
			SIZE_LONG: r = LAST_LONG;
			SIZE_WORD: r = LAST_WORD;
			SIZE_BYTE: r = LAST_BYTE;
			default: r = LAST_LONG;
		endcase
		return r;
	endfunction

	// lanes usable by the mailbox for a given width
	function automatic logic [35:0] lanes_of(input size_mode_t m);
		logic [35:0] r;
		r = MASK_LONG;
		unique case (m)
			SIZE_LONG: r = MASK_LONG;
			SIZE_WORD: r = MASK_WORD;
			SIZE_BYTE: r = MASK_BYTE;
			default: r = MASK_LONG;
		endcase
		return r;
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [35:0] mem [0:DEPTH-1];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W-1:0] wr_ptr_seen_reg;
	logic [PTR_W-1:0] rd_ptr_seen_reg;
	logic [35:0] hold_reg;
	logic [35:0] fifo_out_reg;
	logic [1:0] idx_reg;
	logic ready_reg;
	logic endian_big_reg;
	logic fall_through_reg;
	logic [35:0] mail_reg;
	logic [7:0] ae_offset_reg;
	logic [7:0] af_offset_reg;

	// ****************************************
	// mode decode
	// ****************************************
	// size is read live: the system is trusted to keep it static
	wire size_mode_t size_mode = !BUS_MATCH_SELECT ? SIZE_LONG : (SIZE_SELECT ? SIZE_BYTE : SIZE_WORD);
	wire logic [1:0] last_idx = last_of(size_mode);
	wire logic [35:0] lane_mask = lanes_of(size_mode);

	// ****************************************
	// port a decode and write side
	// ****************************************
	wire logic a_sel = !PORT_A.chip_select_n && PORT_A.write_read && PORT_A.enable;
	wire logic a_fifo_wr = a_sel && !PORT_A.mailbox_select && FLAGS.full_n;
	wire logic a_mail_wr = a_sel && PORT_A.mailbox_select && FLAGS.mailbox_one_n;
	wire logic [PTR_W-1:0] wr_ptr_next = wr_ptr_reg + {8'h0, a_fifo_wr};
	// write side fill level against the retimed read pointer
	wire logic [PTR_W-1:0] count_a_next = wr_ptr_next - rd_ptr_seen_reg;
	wire logic full_n_next = count_a_next != DEPTH_COUNT;
	wire logic [PTR_W-1:0] af_limit = DEPTH_COUNT - {1'b0, af_offset_reg};
	wire logic af_n_next = count_a_next < af_limit;

	// ****************************************
	// port b decode and read side
	// ****************************************
	// fifo read needs chip select low, write/read high, mailbox low
	wire logic b_sel = !PORT_B.chip_select_n && PORT_B.write_read && PORT_B.enable;
	wire logic b_fifo_req = b_sel && !PORT_B.mailbox_select;
	wire logic b_mail_rd = b_sel && PORT_B.mailbox_select;
	// standard mode reads need data stored, fall-through reads need a shown piece
	wire logic b_fifo_rd = b_fifo_req && (fall_through_reg ? ready_reg : FLAGS.empty_n);
	wire logic at_last = idx_reg == last_idx;
	// the location frees only when its final piece goes out
	wire logic [PTR_W-1:0] rd_ptr_next = rd_ptr_reg + {8'h0, b_fifo_rd && at_last};
	wire logic [PTR_W-1:0] count_b_next = wr_ptr_seen_reg - rd_ptr_next;
	wire logic [PTR_W-1:0] count_b = wr_ptr_seen_reg - rd_ptr_reg;
	wire logic avail_next = count_b_next != 9'h000;
	wire logic [35:0] array_word = mem[rd_ptr_next[ADDR_W-1:0]];
	wire logic [1:0] idx_step = (idx_reg + 2'h1) & last_idx;

	// standard mode: first piece comes from the array, the rest from the holding register
	wire logic std_first = b_fifo_rd && idx_reg == 2'h0;
	wire logic [35:0] std_src = std_first ? mem[rd_ptr_reg[ADDR_W-1:0]] : hold_reg;
	// fall-through: refill the output register once it is empty or its last piece is taken
	wire logic ft_load = avail_next && (!ready_reg || (b_fifo_rd && at_last));
	wire logic ft_step = b_fifo_rd && !at_last;

	wire logic [35:0] hold_next = fall_through_reg ? (ft_load ? array_word : hold_reg) :
		(std_first ? std_src : hold_reg);
	wire logic [35:0] fifo_out_next = fall_through_reg ?
		(ft_load ? piece_of(array_word, size_mode, endian_big_reg, 2'h0) :
		(ft_step ? piece_of(hold_reg, size_mode, endian_big_reg, idx_step) : fifo_out_reg)) :
		(b_fifo_rd ? piece_of(std_src, size_mode, endian_big_reg, idx_reg) : fifo_out_reg);
	wire logic [1:0] idx_next = fall_through_reg ?
		(ft_load ? 2'h0 : (ft_step ? idx_step : (b_fifo_rd ? 2'h0 : idx_reg))) :
		(b_fifo_rd ? idx_step : idx_reg);
	// output-ready only falls with the final piece of the last word
	wire logic ready_next = fall_through_reg && (ft_load || (ready_reg && !(b_fifo_rd && at_last)));
	// empty and almost-empty follow the level after the final piece leaves
	wire logic empty_n_next = fall_through_reg ? ready_next : avail_next;
	wire logic ae_n_next = count_b_next > {1'b0, ae_offset_reg};

	// ****************************************
	// mailbox
	// ****************************************
	// a port b read of the mailbox frees it; a write in the same cycle needs a free flag, so none is lost
	wire logic mail_flag_next = a_mail_wr ? 1'b0 : (b_mail_rd ? 1'b1 : FLAGS.mailbox_one_n);
	wire logic [35:0] mail_next = a_mail_wr ? (PORT_A.data & lane_mask) : mail_reg;

	// port b data: mailbox on a mailbox read, held while mailbox select is high without a read, otherwise the fifo output register
	wire logic [35:0] data_b_next = b_mail_rd ? (mail_reg & lane_mask) :
		(PORT_B.mailbox_select ? DATA_B : fifo_out_next);

	// ****************************************
	// register bus
	// ****************************************
	wire logic wr_ae = REG_REQ.wr && REG_REQ.addr == OFS_AE_OFFSET;
	wire logic wr_af = REG_REQ.wr && REG_REQ.addr == OFS_AF_OFFSET;
	wire status_t status_now = '{piece_index: idx_reg, fall_through: fall_through_reg,
		endian_big: endian_big_reg, size_mode: size_mode, flags: FLAGS};
	wire logic [31:0] rd_sel = (REG_REQ.addr == OFS_AE_OFFSET) ? {24'h0, ae_offset_reg} :
		(REG_REQ.addr == OFS_AF_OFFSET) ? {24'h0, af_offset_reg} :
		(REG_REQ.addr == OFS_STATUS) ? {21'h0, status_now} :
		(REG_REQ.addr == OFS_LEVEL) ? {23'h0, count_b} : 32'h0;

	// ****************************************
	// processes
	// ****************************************

	// array write; no reset so it maps onto plain ram
	always_ff @(posedge MCLK) begin
		if (a_fifo_wr) begin
			mem[wr_ptr_reg[ADDR_W-1:0]] <= PORT_A.data;
		end
	end

	// endian and fall-through choice are caught while reset is held
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			endian_big_reg <= ENDIAN_ORDER_SELECT;
			fall_through_reg <= FALL_THROUGH_MODE;
		end
	end

	// pointers and their retimed copies; the extra stage keeps compares off a changing pointer
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			wr_ptr_reg <= 9'h000;
			rd_ptr_reg <= 9'h000;
			wr_ptr_seen_reg <= 9'h000;
			rd_ptr_seen_reg <= 9'h000;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			wr_ptr_seen_reg <= wr_ptr_reg;
			rd_ptr_seen_reg <= rd_ptr_reg;
		end
	end

	// read path registers
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			hold_reg <= 36'h0;
			fifo_out_reg <= 36'h0;
			idx_reg <= 2'h0;
			ready_reg <= 1'b0;
			DATA_B <= 36'h0;
		end else begin
			hold_reg <= hold_next;
			fifo_out_reg <= fifo_out_next;
			idx_reg <= idx_next;
			ready_reg <= ready_next;
			DATA_B <= data_b_next;
		end
	end

	// flags; all low in reset except the free mailbox
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			FLAGS <= '{empty_n: 1'b0, full_n: 1'b0, almost_empty_n: 1'b0, almost_full_n: 1'b0,
				mailbox_one_n: 1'b1};
		end else begin
			FLAGS <= '{empty_n: empty_n_next, full_n: full_n_next, almost_empty_n: ae_n_next,
				almost_full_n: af_n_next, mailbox_one_n: mail_flag_next};
		end
	end

	// mailbox data survives reads and changes only on an accepted write
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			mail_reg <= 36'h0;
		end else begin
			mail_reg <= mail_next;
		end
	end

	// offsets and read data; read data stands only in the cycle after the strobe
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			ae_offset_reg <= AE_OFFSET_RESET;
			af_offset_reg <= AF_OFFSET_RESET;
			REG_RDATA <= 32'h0;
		end else begin
			if (wr_ae) begin
				ae_offset_reg <= REG_REQ.wdata[7:0];
			end
			if (wr_af) begin
				af_offset_reg <= REG_REQ.wdata[7:0];
			end
			REG_RDATA <= REG_REQ.rd ? rd_sel : 32'h0;
		end
	end

endmodule

// File: fifo_bus_match_properties.sv
// checker for the port behaviour of the bus-matching fifo
`timescale 1ns/1ps
module fifo_bus_match_checker
	import fifo_match_pkg::*;
(
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic BUS_MATCH_SELECT,
	input wire logic SIZE_SELECT,
	input wire port_a_req_t PORT_A,
	input wire port_b_req_t PORT_B,
	input wire reg_req_t REG_REQ,
	input wire logic [35:0] DATA_B,
	input wire flags_t FLAGS
);
	// ****
	// request decodes
	// ****
	wire a_sel = !PORT_A.chip_select_n && PORT_A.write_read && PORT_A.enable;
	wire b_sel = !PORT_B.chip_select_n && PORT_B.write_read && PORT_B.enable;
	wire fifo_wr = a_sel && !PORT_A.mailbox_select && FLAGS.full_n;
	wire fifo_rd = b_sel && !PORT_B.mailbox_select && FLAGS.empty_n;
	wire mail_wr = a_sel && PORT_A.mailbox_select && FLAGS.mailbox_one_n;
	wire mail_rd = b_sel && PORT_B.mailbox_select;
	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);
	// flags move only for their own cause; a far-side pointer move reaches them after the retiming stage
	// write edge, retimed pointer edge, flag edge: the rise is seen three samples after the write
	chk_empty_rise: assert property ($rose(FLAGS.empty_n) |-> $past(fifo_wr, 3))
		else $error("empty flag rose without a write");
	chk_empty_hold: assert property (FLAGS.empty_n && !fifo_rd |=> FLAGS.empty_n)
		else $error("empty flag fell without a read");
	chk_full_rise: assert property (!$past(SRST, 2) && $rose(FLAGS.full_n) |-> $past(fifo_rd, 3))
		else $error("full flag rose without a read");
	// the flag leaves reset low and is raised at the first edge after release
	chk_full_hold: assert property (!$past(SRST) && !FLAGS.full_n && !fifo_rd && !$past(fifo_rd)
		&& !$past(fifo_rd, 2) |=> !FLAGS.full_n)
		else $error("full flag freed without a read");
	// a new offset reaches the flag one edge after it is written
	chk_ae_hold: assert property (FLAGS.almost_empty_n && !fifo_rd && !REG_REQ.wr && !$past(REG_REQ.wr)
		|=> FLAGS.almost_empty_n)
		else $error("almost empty fell without a read");
	chk_af_rise: assert property (!$past(SRST, 2) && !$past(REG_REQ.wr) && !$past(REG_REQ.wr, 2)
		&& $rose(FLAGS.almost_full_n) |-> $past(fifo_rd, 3))
		else $error("almost full rose without a read");
	chk_mail_set: assert property (mail_wr |=> !FLAGS.mailbox_one_n)
		else $error("mail write left flag high");
	chk_mail_clear: assert property (mail_rd && !mail_wr |=> FLAGS.mailbox_one_n)
		else $error("mail read left flag low");
	chk_mail_keep: assert property (!FLAGS.mailbox_one_n && !mail_rd |=> !FLAGS.mailbox_one_n)
		else $error("mail flag rose without a read");
	chk_word_lanes: assert property (BUS_MATCH_SELECT && !SIZE_SELECT |-> DATA_B[35:18] == 18'h0)
		else $error("upper word lanes not quiet");
	chk_byte_lanes: assert property (BUS_MATCH_SELECT && SIZE_SELECT |-> DATA_B[35:9] == 27'h0)
		else $error("upper byte lanes not quiet");
endmodule
bind fifo_bus_match fifo_bus_match_checker u_chk (.MCLK, .SRST, .BUS_MATCH_SELECT, .SIZE_SELECT,
	.PORT_A, .PORT_B, .REG_REQ, .DATA_B, .FLAGS);

// File: fifo_far_side.sv
// behavioural writer on port a and reader on port b
`timescale 1ns/1ps
module fifo_far_side
	import fifo_match_pkg::*;
(
	input wire logic clk,
	output port_a_req_t port_a,
	output port_b_req_t port_b
);
	// both ports idle at time zero
	initial begin
		port_a = '{1'b1, 1'b0, 1'b0, 1'b0, 36'h0};
		port_b = '{1'b1, 1'b0, 1'b0, 1'b0};
	end
	// one write; idle data is inverted so a stale bus never looks valid
	task automatic put_a(input logic mb, input logic [35:0] d);
		@(posedge clk);
		port_a <= '{1'b0, 1'b1, 1'b1, mb, d};
		@(posedge clk);
		port_a <= '{1'b1, 1'b0, 1'b0, 1'b0, ~d};
	endtask
	// one read after a stall of gap cycles
	task automatic get_b(input logic mb, input int gap);
		repeat (gap) @(posedge clk);
		port_b <= '{1'b0, 1'b1, 1'b1, mb};
		@(posedge clk);
		port_b <= '{1'b1, 1'b0, 1'b0, 1'b0};
	endtask
endmodule

// File: bus_matching_fifo_read_flags_test.sv
// self-checking bench for the bus-matching fifo
`timescale 1ns/1ps
module bus_matching_fifo_read_flags_test
	import fifo_match_pkg::*;
;
	// ****
	// signals and instances
	// ****
	logic mclk, srst, bm_sel, size_sel, endian_sel, ft_sel;
	reg_req_t reg_req;
	logic [31:0] reg_rdata;
	logic [35:0] data_b, word;
	flags_t flags;
	port_a_req_t port_a;
	port_b_req_t port_b;
	int fail_count = 0;
	int check_count = 0;
	logic [3:0] cfg [7] = '{4'h0, 4'h5, 4'h4, 4'h7, 4'h6, 4'hf, 4'hc}; // ft, bm, size, endian
	always #50 mclk = ~mclk;
	fifo_bus_match u_dut (.MCLK(mclk), .SRST(srst), .BUS_MATCH_SELECT(bm_sel), .SIZE_SELECT(size_sel),
		.ENDIAN_ORDER_SELECT(endian_sel), .FALL_THROUGH_MODE(ft_sel), .PORT_A(port_a), .PORT_B(port_b),
		.REG_REQ(reg_req), .REG_RDATA(reg_rdata), .DATA_B(data_b), .FLAGS(flags));
	fifo_far_side u_far (.clk(mclk), .port_a(port_a), .port_b(port_b));
	// compares and closing report
	task automatic cmp_data(input logic [35:0] got, input logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic [1:0] got, input logic [1:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// register bus: one-cycle strobes, read data in the following cycle only
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		reg_req <= '0;
	endtask
	task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
		@(posedge mclk);
		reg_req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge mclk);
		reg_req <= '0;
		#1 cmp_data({4'h0, reg_rdata}, {4'h0, exp});
	endtask
	// modes only change while reset is held
	task automatic reset_dut(input logic [3:0] c);
		@(posedge mclk);
		srst <= 1'b1;
		{ft_sel, bm_sel, size_sel, endian_sel} <= c;
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	// expected piece i of a long word for a mode
	function automatic logic [35:0] piece(input logic [3:0] c, input logic [35:0] d, input int i);
		int j;
		if (!c[2])
			return d;
		j = c[0] ? i : (c[1] ? 3 - i : 1 - i);
		if (!c[1])
			return {18'h0, j == 0 ? d[35:18] : d[17:0]};
		return {27'h0, d[35 - 9 * j -: 9]};
	endfunction
	// main sequence: seven mode settings, with the mailbox case in the fourth and the full-fifo case in the fifth
	initial begin
		int n;
		mclk = 1'b0;
		srst = 1'b1;
		{ft_sel, bm_sel, size_sel, endian_sel} = 4'h0;
		reg_req = '0;
		for (int k = 0; k < 7; k++) begin
			reset_dut(cfg[k]);
			n = !cfg[k][2] ? 1 : (cfg[k][1] ? 4 : 2);
			word = 36'h9_8765_4321 + 36'(k);
			reg_read(4'h0, 32'h8);
			reg_read(4'h8, {23'h0, cfg[k][3], cfg[k][0], cfg[k][1], cfg[k][2], 5'h0b});
			reg_read(4'h2, 32'h0);
			reg_write(4'h0, 32'h0);
			u_far.put_a(1'b0, word);
			#1 cmp_flag({flags.empty_n, flags.almost_empty_n}, 2'b00);
			// the retimed pointer holds the flags low for one more edge
			@(posedge mclk);
			#1 cmp_flag({flags.empty_n, flags.almost_empty_n}, 2'b00);
			@(posedge mclk);
			#1 cmp_flag({flags.empty_n, flags.almost_empty_n}, 2'b11);
			for (int i = 0; i < n; i++) begin
				if (cfg[k][3]) cmp_data(data_b, piece(cfg[k], word, i));
				u_far.get_b(1'b0, 1 + i);
				#1 if (!cfg[k][3]) cmp_data(data_b, piece(cfg[k], word, i));
				cmp_flag({flags.empty_n, flags.almost_empty_n}, {2{i < n - 1}});
			end
			if (k == 3) begin
				u_far.put_a(1'b1, word);
				#1 cmp_flag({flags.mailbox_one_n, 1'b0}, 2'b00);
				u_far.put_a(1'b1, ~word);
				u_far.get_b(1'b1, 2);
				#1 cmp_data(data_b, word & MASK_BYTE);
				cmp_flag({flags.mailbox_one_n, 1'b0}, 2'b10);
			end
			if (k == 4) begin
				for (int w = 0; w < 257; w++)
					u_far.put_a(1'b0, word + 36'(w));
				#1 cmp_flag({flags.full_n, flags.almost_full_n}, 2'b00);
				reg_read(4'hc, 32'h100);
				for (int i = 0; i < 4; i++) begin
					u_far.get_b(1'b0, 1);
					#1 cmp_data(data_b, piece(cfg[k], word, i));
					cmp_flag({flags.full_n, 1'b0}, 2'b00);
				end
				// freed location shows on the write side two edges after the final piece
				@(posedge mclk);
				#1 cmp_flag({flags.full_n, flags.almost_full_n}, 2'b00);
				@(posedge mclk);
				#1 cmp_flag({flags.full_n, flags.almost_full_n}, 2'b10);
				for (int i = 0; i < 32; i++)
					u_far.get_b(1'b0, 1);
				@(posedge mclk);
				#1 cmp_flag({flags.full_n, flags.almost_full_n}, 2'b10);
				@(posedge mclk);
				#1 cmp_flag({flags.full_n, flags.almost_full_n}, 2'b11);
			end
		end
		complete_run;
	end
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		complete_run;
	end
endmodule
